// ### inc/ext_cfg_pkg.sv
package ext_cfg_pkg;
	localparam int          CLKS_PER_STATE   = 2;
	localparam logic [23:0] CFG1_ADDR        = 24'hFFFFF9;
	localparam logic [23:0] ALIAS_CODE_BASE  = 24'hFF4000;
	localparam logic [7:0]  ALIAS_DATA_REG   = 8'h00;
	localparam logic [1:0]  ALIAS_DATA_TOP   = 2'h3;
	localparam logic [7:0]  CFG1_RESET       = 8'hFF;
	localparam logic [9:0]  SIZE_SMALL_KB    = 10'h010;
	localparam logic [9:0]  SIZE_LARGE_KB    = 10'h020;
	localparam logic [9:0]  EXT_256_KB       = 10'h100;
	localparam logic [9:0]  EXT_128_KB       = 10'h080;
	localparam logic [9:0]  EXT_64_KB        = 10'h040;
	localparam logic [2:0]  FRAME_SHORT      = 3'h2;
	localparam logic [2:0]  FRAME_LONG       = 3'h4;
	localparam logic [2:0]  WAIT_MAX         = 3'h4;
	localparam logic [2:0]  NONPAGE_BASE     = 3'h2;
	localparam logic [6:0]  REGION_LO_MASK   = 7'h00;
	localparam logic [6:0]  REGION_HI_MASK   = 7'h7F;

	// second configuration byte, msb first
	typedef struct packed {
		logic code_size_sel;
		logic rsvd6;
		logic rsvd5;
		logic irq_frame_size;
		logic wait_b_compat;
		logic wait_b_count_hi_n;
		logic wait_b_count_lo_n;
		logic code_to_data_alias_n;
	} config_byte_second_type;

	typedef enum logic [1:0] {
		ROLE_IO,
		ROLE_ADDR,
		ROLE_READ_STROBE
	} pin_role_type;

	typedef struct packed {
		logic [9:0]   code_kb;
		logic [2:0]   frame_bytes;
		logic [1:0]   wait_b;
		logic         alias_on;
		pin_role_type port1_bit7_role;
		pin_role_type port3_bit7_role;
		logic [9:0]   ext_kb;
	} decoded_type;

	typedef enum logic [1:0] {
		STK_PC_LOW,
		STK_PC_MID,
		STK_PC_HIGH,
		STK_STATUS
	} stack_byte_type;
endpackage

// ### logic/external_bus_config_decode.sv
`timescale 1ns/1ns
module external_bus_config_decode
	import ext_cfg_pkg::*;
#(
	parameter bit PROGRAMMABLE = 1'b1,
	parameter int QUEUE_DEPTH  = 4
) (
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   external_access_n_i,
	input  wire logic [7:0]             onchip_config_i,
	input  wire logic [7:0]             ext_data_i,
	input  wire logic                   ext_data_valid_i,
	input  wire logic [1:0]             strobe_map_i,
	input  wire logic [23:0]            data_addr_i,
	input  wire logic [23:0]            ext_addr_i,
	input  wire logic                   irq_entry_i,
	input  wire logic                   return_from_irq_i,
	input  wire logic                   page_mode_i,
	input  wire logic                   fetch_onchip_i,
	input  wire logic [2:0]             ext_wait_i,
	input  wire logic [2:0]             instr_size_i,
	input  wire logic [5:0]             exec_states_i,
	input  wire logic                   instr_take_i,
	input  wire logic                   bus_busy_i,
	output logic                        ext_fetch_req_o,
	output logic [23:0]                 ext_fetch_addr_o,
	output logic                        config_ready_o,
	output config_byte_second_type      config_byte_second_o,
	output decoded_type                 decoded_o,
	output logic                        state_tick_o,
	output logic                        stack_push_o,
	output logic                        stack_pop_o,
	output stack_byte_type              stack_byte_o,
	output logic                        alias_hit_o,
	output logic [23:0]                 alias_code_addr_o,
	output logic                        port1_bit7_addr_o,
	output logic                        port3_bit7_addr_o,
	output logic                        port3_read_sel_o,
	output logic                        program_read_sel_o,
	output logic [5:0]                  bound_states_o,
	output logic [3:0]                  queue_level_o,
	output logic                        fetch_stall_o
);
	typedef enum logic [2:0] {
		LD_START,
		LD_SETTLE,
		LD_REQ,
		LD_WAIT,
		LD_DONE
	} load_state_type;

	logic           ea_meta_reg;
	logic           ea_sync_reg;
	load_state_type load_reg;
	config_byte_second_type cfg_reg;
	logic           tick_phase_reg;
	logic [2:0]     stack_left_reg;
	logic           stack_pop_mode_reg;
	logic [5:0]     fetch_cnt_reg;
	logic [3:0]     level_reg;
	logic [5:0]     byte_cost;
	logic [5:0]     fetch_states;
	logic [2:0]     wait_clip;
	logic           state_edge;
	logic [2:0]     frame_now;

	// access pin is a board strap: two flops before the loader looks at it
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ea_meta_reg <= 1'b1;
			ea_sync_reg <= 1'b1;
		end else begin
			ea_meta_reg <= external_access_n_i;
			ea_sync_reg <= ea_meta_reg;
		end
	end

	// loader: one pass after reset release; the strap is read three cycles in,
	// once both synchroniser flops hold the pin rather than their reset value
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			load_reg         <= LD_START;
			cfg_reg          <= CFG1_RESET;
			ext_fetch_req_o  <= 1'b0;
			ext_fetch_addr_o <= 24'h000000;
			config_ready_o   <= 1'b0;
		end else begin
			case (load_reg)
				LD_START: begin
					load_reg <= LD_SETTLE;
				end
				LD_SETTLE: begin
					load_reg <= LD_REQ;
				end
				LD_REQ: begin
					if (!ea_sync_reg) begin
						ext_fetch_req_o  <= 1'b1;
						ext_fetch_addr_o <= CFG1_ADDR;
						load_reg         <= LD_WAIT;
					end else begin
						cfg_reg        <= onchip_config_i;
						config_ready_o <= 1'b1;
						load_reg       <= LD_DONE;
					end
				end
				LD_WAIT: begin
					// request stays up until memory answers
					if (ext_data_valid_i) begin
						cfg_reg         <= ext_data_i;
						ext_fetch_req_o <= 1'b0;
						config_ready_o  <= 1'b1;
						load_reg        <= LD_DONE;
					end
				end
				LD_DONE: begin
					load_reg <= LD_DONE;
				end
				default: begin
					load_reg <= LD_START;
				end
			endcase
		end
	end

	assign config_byte_second_o = cfg_reg;

	// decode fields; reserved bits 6 and 5 are ignored whatever was written
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			decoded_o <= '0;
		end else begin
			if (PROGRAMMABLE) begin
				decoded_o.code_kb <= cfg_reg.code_size_sel ? SIZE_LARGE_KB : SIZE_SMALL_KB;
			end else begin
				decoded_o.code_kb <= SIZE_LARGE_KB;
			end
			decoded_o.frame_bytes <= cfg_reg.irq_frame_size ? FRAME_LONG : FRAME_SHORT;
			// legacy single bit not consulted: the two-bit field governs
			decoded_o.wait_b   <= ~{cfg_reg.wait_b_count_hi_n, cfg_reg.wait_b_count_lo_n};
			decoded_o.alias_on <= ~cfg_reg.code_to_data_alias_n;
			case (strobe_map_i)
				2'b00: begin
					decoded_o.port1_bit7_role <= ROLE_ADDR;
					decoded_o.port3_bit7_role <= ROLE_ADDR;
					decoded_o.ext_kb          <= EXT_256_KB;
				end
				2'b01: begin
					decoded_o.port1_bit7_role <= ROLE_IO;
					decoded_o.port3_bit7_role <= ROLE_ADDR;
					decoded_o.ext_kb          <= EXT_128_KB;
				end
				2'b10: begin
					decoded_o.port1_bit7_role <= ROLE_IO;
					decoded_o.port3_bit7_role <= ROLE_IO;
					decoded_o.ext_kb          <= EXT_64_KB;
				end
				default: begin
					decoded_o.port1_bit7_role <= ROLE_IO;
					decoded_o.port3_bit7_role <= ROLE_READ_STROBE;
					decoded_o.ext_kb          <= EXT_128_KB;
				end
			endcase
		end
	end

	// address pins and read strobe steering for the current external access
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			port1_bit7_addr_o  <= 1'b0;
			port3_bit7_addr_o  <= 1'b0;
			port3_read_sel_o   <= 1'b0;
			program_read_sel_o <= 1'b0;
		end else begin
			port1_bit7_addr_o <= (strobe_map_i == 2'b00) & ext_addr_i[17];
			port3_bit7_addr_o <= ~strobe_map_i[1] & ext_addr_i[16];
			if (strobe_map_i == 2'b11) begin
				// regions 00:/01: vs FE:/FF: decoded from bits 23:17; other regions select neither
				port3_read_sel_o   <= (ext_addr_i[23:17] == REGION_LO_MASK);
				program_read_sel_o <= (ext_addr_i[23:17] == REGION_HI_MASK);
			end else begin
				port3_read_sel_o   <= 1'b0;
				program_read_sel_o <= 1'b1;
			end
		end
	end

	// data space alias of the upper on-chip code window
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			alias_hit_o       <= 1'b0;
			alias_code_addr_o <= 24'h000000;
		end else begin
			alias_hit_o <= ~cfg_reg.code_to_data_alias_n & config_ready_o
				& (data_addr_i[23:16] == ALIAS_DATA_REG)
				& (data_addr_i[15:14] == ALIAS_DATA_TOP);
			alias_code_addr_o <= ALIAS_CODE_BASE | {10'h000, data_addr_i[13:0]};
		end
	end

	// execution state timebase: one state per two clocks
	assign state_edge = (tick_phase_reg == 1'(CLKS_PER_STATE - 1));

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_phase_reg <= 1'b0;
			state_tick_o   <= 1'b0;
		end else begin
			tick_phase_reg <= ~tick_phase_reg;
			state_tick_o   <= state_edge;
		end
	end

	assign frame_now = cfg_reg.irq_frame_size ? FRAME_LONG : FRAME_SHORT;

	// stack frame sequencer: one byte per state; entry pushes, return pops
	// a new entry or return while a frame is moving is ignored
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stack_left_reg     <= 3'h0;
			stack_pop_mode_reg <= 1'b0;
			stack_push_o       <= 1'b0;
			stack_pop_o        <= 1'b0;
			stack_byte_o       <= STK_PC_LOW;
		end else begin
			stack_push_o <= 1'b0;
			stack_pop_o  <= 1'b0;
			if (stack_left_reg == 3'h0) begin
				if (irq_entry_i) begin
					stack_left_reg     <= frame_now;
					stack_pop_mode_reg <= 1'b0;
				end else if (return_from_irq_i) begin
					stack_left_reg     <= frame_now;
					stack_pop_mode_reg <= 1'b1;
				end
			end else if (state_edge) begin
				stack_left_reg <= stack_left_reg - 3'h1;
				stack_push_o   <= ~stack_pop_mode_reg;
				stack_pop_o    <= stack_pop_mode_reg;
				if (stack_pop_mode_reg) begin
					// pops run in reverse of push order
					stack_byte_o <= stack_byte_type'(2'(stack_left_reg - 3'h1));
				end else begin
					stack_byte_o <= stack_byte_type'(2'(frame_now - stack_left_reg));
				end
			end
		end
	end

	// fetch cost per byte in states; beyond four waits is clipped
	assign wait_clip = (ext_wait_i > WAIT_MAX) ? WAIT_MAX : ext_wait_i;
	assign byte_cost = page_mode_i ? 6'h01 : 6'(NONPAGE_BASE + wait_clip);
	assign fetch_states = fetch_onchip_i ? 6'h00 : 6'(instr_size_i * byte_cost);

	// throughput bound for the instruction being issued
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bound_states_o <= 6'h00;
		end else begin
			bound_states_o <= (exec_states_i > fetch_states) ? exec_states_i : fetch_states;
		end
	end

	// prefetch queue level: external bytes arrive one per byte_cost states
	// only when the bus is free; on-chip code keeps it topped up
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fetch_cnt_reg <= 6'h00;
			level_reg     <= 4'h0;
			fetch_stall_o <= 1'b0;
		end else begin
			logic fill;
			logic take;
			fill = 1'b0;
			take = instr_take_i & ({1'b0, instr_size_i} <= level_reg);
			if (fetch_onchip_i) begin
				fetch_cnt_reg <= 6'h00;
				fill          = 1'b1;
			end else if (state_edge & ~bus_busy_i & (level_reg < 4'(QUEUE_DEPTH))) begin
				if (fetch_cnt_reg + 6'h01 >= byte_cost) begin
					fetch_cnt_reg <= 6'h00;
					fill          = 1'b1;
				end else begin
					fetch_cnt_reg <= fetch_cnt_reg + 6'h01;
				end
			end
			if (fetch_onchip_i) begin
				level_reg <= 4'(QUEUE_DEPTH);
			end else if (take) begin
				level_reg <= level_reg - {1'b0, instr_size_i} + {3'h0, fill};
			end else if (fill) begin
				level_reg <= level_reg + 4'h1;
			end
			fetch_stall_o <= instr_take_i & ~take;
		end
	end

	assign queue_level_o = level_reg;
endmodule

// ### sim/ext_cfg_chk.sv
`timescale 1ns/1ns
module ext_cfg_chk
	import ext_cfg_pkg::*;
(
	input wire logic                   clk_i,
	input wire logic                   reset_i,
	input wire logic                   external_access_n_i,
	input wire logic [7:0]             ext_data_i,
	input wire logic                   ext_data_valid_i,
	input wire logic [1:0]             strobe_map_i,
	input wire logic [23:0]            data_addr_i,
	input wire logic [23:0]            ext_addr_i,
	input wire logic [5:0]             exec_states_i,
	input wire logic                   ext_fetch_req_o,
	input wire logic [23:0]            ext_fetch_addr_o,
	input wire logic                   config_ready_o,
	input wire config_byte_second_type config_byte_second_o,
	input wire decoded_type            decoded_o,
	input wire logic                   state_tick_o,
	input wire logic                   stack_push_o,
	input wire logic                   stack_pop_o,
	input wire stack_byte_type         stack_byte_o,
	input wire logic                   alias_hit_o,
	input wire logic                   port1_bit7_addr_o,
	input wire logic                   port3_bit7_addr_o,
	input wire logic                   port3_read_sel_o,
	input wire logic                   program_read_sel_o,
	input wire logic [5:0]             bound_states_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence push_at(stack_byte_type b); stack_push_o && stack_byte_o == b; endsequence
	sequence pop_at(stack_byte_type b); stack_pop_o && stack_byte_o == b; endsequence

	a_tick_alternates: assert property (state_tick_o |=> !state_tick_o ##1 state_tick_o) else $error("tick spacing");
	a_ready_sticky: assert property (config_ready_o |=> config_ready_o) else $error("ready dropped");
	a_fetch_addr: assert property (ext_fetch_req_o |-> ext_fetch_addr_o == CFG1_ADDR && !config_ready_o)
		else $error("config fetch address");
	a_load_answer: assert property (ext_fetch_req_o && ext_data_valid_i |=> !ext_fetch_req_o && config_ready_o
		&& config_byte_second_o == $past(ext_data_i)) else $error("external byte not loaded");
	a_onchip_quiet: assert property (external_access_n_i && $past(external_access_n_i, 3) |-> !ext_fetch_req_o)
		else $error("fetch with strap high");
	a_decode_fields: assert property (config_ready_o && $past(config_ready_o) |-> decoded_o.wait_b == ~config_byte_second_o[2:1]
		&& decoded_o.frame_bytes == (config_byte_second_o.irq_frame_size ? FRAME_LONG : FRAME_SHORT)) else $error("decode");
	a_pin_roles: assert property (!$past(reset_i) |-> port1_bit7_addr_o == ($past(strobe_map_i) == 2'h0
		&& $past(ext_addr_i[17])) && port3_bit7_addr_o == (!$past(strobe_map_i[1]) && $past(ext_addr_i[16])))
		else $error("port roles");
	a_region_split: assert property (!$past(reset_i) && $past(strobe_map_i) == 2'h3
		|-> program_read_sel_o == ($past(ext_addr_i[23:17]) == REGION_HI_MASK)
		&& port3_read_sel_o == ($past(ext_addr_i[23:17]) == REGION_LO_MASK)) else $error("region split");
	a_alias_hit: assert property (config_ready_o && $past(config_ready_o, 2) |-> alias_hit_o ==
		(!config_byte_second_o.code_to_data_alias_n && $past(data_addr_i[23:14]) == 10'h003)) else $error("alias");
	a_long_frame: assert property (push_at(STK_PC_MID) ##0 config_byte_second_o.irq_frame_size
		|-> ##2 push_at(STK_PC_HIGH) ##2 push_at(STK_STATUS)) else $error("long frame order");
	a_short_frame: assert property (push_at(STK_PC_MID) ##0 !config_byte_second_o.irq_frame_size
		|=> !stack_push_o [*4]) else $error("short frame overrun");
	a_pop_order: assert property (pop_at(STK_PC_MID) |-> ##2 pop_at(STK_PC_LOW)) else $error("pop order");
	a_bound_max: assert property (!$past(reset_i) |-> bound_states_o >= $past(exec_states_i))
		else $error("bound below execution");
endmodule

bind external_bus_config_decode ext_cfg_chk ext_cfg_chk_inst (.*);

// ### sim/ext_code_mem.sv
`timescale 1ns/1ns
// external memory holding the single configuration byte at CFG1_ADDR, answering after lat_i cycles
module ext_code_mem
	import ext_cfg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        req_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic [3:0]  lat_i,
	output logic [7:0]       data_o,
	output logic             valid_o
);
	logic [3:0] cnt;
	logic       done;

	// data toggles when not answering so a stale byte is never mistaken for valid
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			valid_o <= 1'b0;
			data_o  <= 8'h5A;
			cnt     <= 4'h0;
			done    <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			data_o  <= ~data_o;
			if (!req_i) begin
				cnt  <= 4'h0;
				done <= 1'b0;
			end else if (!done && addr_i === CFG1_ADDR) begin
				if (cnt == lat_i) begin
					valid_o <= 1'b1;
					data_o  <= byte_i;
					done    <= 1'b1;
				end else
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

// ### sim/external_bus_config_decode_test.sv
`timescale 1ns/1ns
module external_bus_config_decode_test;
	import ext_cfg_pkg::*;
	logic clk_i = 1'b0, reset_i = 1'b1, external_access_n_i = 1'b0, fetch_onchip_i = 1'b0;
	logic irq_entry_i = 1'b0, return_from_irq_i = 1'b0, page_mode_i = 1'b0, instr_take_i = 1'b0, bus_busy_i = 1'b0;
	logic [7:0] onchip_config_i = 8'hFF, mem_byte = 8'hFF, ext_data_i;
	logic [1:0] strobe_map_i = 2'h0;
	logic [23:0] data_addr_i = 24'h0, ext_addr_i = 24'h0, ext_fetch_addr_o, alias_code_addr_o, ea;
	logic [2:0] ext_wait_i = 3'h0, instr_size_i = 3'h1;
	logic [5:0] exec_states_i = 6'h0, bound_states_o;
	logic [3:0] mem_lat = 4'h0, queue_level_o;
	logic ext_data_valid_i, ext_fetch_req_o, config_ready_o, state_tick_o, stack_push_o, stack_pop_o, alias_hit_o;
	logic port1_bit7_addr_o, port3_bit7_addr_o, port3_read_sel_o, program_read_sel_o, fetch_stall_o;
	config_byte_second_type config_byte_second_o;
	decoded_type decoded_o;
	stack_byte_type stack_byte_o;
	int errors = 0, total_checks = 0, seed = 19, i, j, n, r, sz, w, ex, fc;
	// ones kept in the reserved positions; covers all four wait codes and both frame sizes
	// the legacy wait bit stays set in every entry since the two-bit field is in use
	logic [7:0] cfg_table [4] = '{8'hEC, 8'h7B, 8'hE8, 8'hFF};
	logic [9:0] kb_table [4] = '{EXT_256_KB, EXT_128_KB, EXT_64_KB, EXT_128_KB};

	external_bus_config_decode external_bus_config_decode_inst (.*);
	ext_code_mem ext_code_mem_inst (.clk_i(clk_i), .reset_i(reset_i), .req_i(ext_fetch_req_o),
		.addr_i(ext_fetch_addr_o), .byte_i(mem_byte), .lat_i(mem_lat), .data_o(ext_data_i), .valid_o(ext_data_valid_i));

	always #25 clk_i = ~clk_i;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// reset with a new strap level; odd entries load from on-chip, the rest from the bus
	task load(input int k);
		@(posedge clk_i);
		reset_i <= 1'b1;
		external_access_n_i <= k[0];
		mem_byte <= cfg_table[k];
		onchip_config_i <= cfg_table[k];
		mem_lat <= k[1] ? 4'h5 : 4'h0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		n = 0;
		while (config_ready_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		check(n < 50, 1);
		repeat (2) @(posedge clk_i);
		#1;
		check(config_byte_second_o, cfg_table[k]);
		check(decoded_o.code_kb, cfg_table[k][7] ? SIZE_LARGE_KB : SIZE_SMALL_KB);
		check(decoded_o.wait_b, {30'h0, ~cfg_table[k][2:1]});
		check(decoded_o.alias_on, !cfg_table[k][0]);
	endtask

	// one entry or return, then count the stack strobes it produces
	task frame(input logic pop, input logic [2:0] exp);
		@(posedge clk_i);
		irq_entry_i <= !pop;
		return_from_irq_i <= pop;
		@(posedge clk_i);
		irq_entry_i <= 1'b0;
		return_from_irq_i <= 1'b0;
		n = 0;
		repeat (14) begin
			@(posedge clk_i);
			#1;
			n += pop ? stack_pop_o : stack_push_o;
		end
		check(n, exp);
	endtask

	initial begin
		for (i = 0; i < 4; i++) begin
			load(i);
			frame(1'b0, cfg_table[i][4] ? FRAME_LONG : FRAME_SHORT);
			frame(1'b1, cfg_table[i][4] ? FRAME_LONG : FRAME_SHORT);
			// on-chip code fills the queue to its default depth of four
			@(posedge clk_i);
			fetch_onchip_i <= 1'b1;
			instr_take_i <= 1'b0;
			repeat (2) @(posedge clk_i);
			#1;
			check(queue_level_o, 4);
			// a five-byte take from a four-byte queue with the bus held must stall
			@(posedge clk_i);
			fetch_onchip_i <= 1'b0;
			bus_busy_i <= 1'b1;
			instr_size_i <= 3'h5;
			instr_take_i <= 1'b1;
			@(posedge clk_i);
			#1;
			check(fetch_stall_o, 1);
			instr_take_i <= 1'b0;
			// alias window edges first, then random addresses
			for (j = 0; j < 12; j++) begin
				r = $random(seed);
				ea = j == 0 ? 24'h00C000 : j == 1 ? 24'h00FFFF : j == 2 ? 24'h00BFFF : j == 3 ? 24'h01C000 : r;
				@(posedge clk_i);
				data_addr_i <= ea;
				@(posedge clk_i);
				#1;
				check(alias_hit_o, !cfg_table[i][0] && ea[23:14] == 10'h003);
				if (ea[23:14] == 10'h003 && !cfg_table[i][0])
					check(alias_code_addr_o, {8'hFF, 2'h1, ea[13:0]});
			end
			// strobe map sweep with fetch cost, the worst-case fetch forced first
			for (j = 0; j < 16; j++) begin
				r = $random(seed);
				ea = $random(seed);
				if (j[2])
					ea[23:17] = REGION_LO_MASK;
				if (j[3])
					ea[23:17] = REGION_HI_MASK;
				sz = (r & 7) % 5 + 1;
				w = (r >> 3) & 7;
				ex = (r >> 6) & 31;
				if (j == 0) begin
					sz = 5;
					w = 7;
					r[11] = 1'b0;
				end
				fc = r[11] ? sz : sz * (2 + (w > 4 ? 4 : w));
				@(posedge clk_i);
				strobe_map_i <= j[1:0];
				ext_addr_i <= ea;
				instr_size_i <= sz[2:0];
				ext_wait_i <= w[2:0];
				exec_states_i <= ex[5:0];
				page_mode_i <= r[11];
				bus_busy_i <= r[12];
				instr_take_i <= r[13];
				@(posedge clk_i);
				#1;
				check(port1_bit7_addr_o, j[1:0] == 0 && ea[17]);
				check(port3_bit7_addr_o, j[1] == 0 && ea[16]);
				check(port3_read_sel_o, j[1:0] == 3 && ea[23:17] == REGION_LO_MASK);
				check(program_read_sel_o, j[1:0] != 3 || ea[23:17] == REGION_HI_MASK);
				check(decoded_o.ext_kb, kb_table[j[1:0]]);
				check(bound_states_o, ex > fc ? ex : fc);
			end
		end
		stop_test;
	end

	// a hang cuts the run short well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		stop_test;
	end
endmodule
